// ==== rx_signaling_substitution_array.sv ====
// rx_signaling_substitution_array: per-timeslot receive signaling substitution
// values and received signaling array, with debounce, behind an avalon-mm slave.
// assumes samples and superframe strobe come from framer logic on clock_i.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module rx_signaling_substitution_array #(
    parameter int NUM_TS = rx_sig_pkg::NUM_TS
) (
    // clock and reset
    input  wire logic                           clock_i,
    input  wire logic                           reset_i,
    // avalon-mm slave
    input  wire logic [rx_sig_pkg::ADDR_W-1:0]  address_i,
    input  wire logic                           read_i,
    input  wire logic                           write_i,
    input  wire logic [rx_sig_pkg::DATA_W-1:0]  writedata_i,
    input  wire logic [3:0]                     byteenable_i,
    output logic      [rx_sig_pkg::DATA_W-1:0]  readdata_o,
    output logic                                waitrequest_o,
    // receive framer
    input  wire rx_sig_pkg::sig_sample_t        rx_sample_i,
    input  wire logic                           superframe_end_i,
    // outgoing pcm signaling and signaling pin
    output var  rx_sig_pkg::sig_sample_t        rx_pcm_out_o,
    output var  rx_sig_pkg::sig_sample_t        rx_signaling_pin_o
);
    import rx_sig_pkg::*;

    chan_ctrl_t        ctrl_q     [NUM_TS];
    logic [3:0]        sub_q      [NUM_TS];
    logic [3:0]        arr_q      [NUM_TS];
    logic [3:0]        prev_q     [NUM_TS];
    logic [3:0]        pend_val_q [NUM_TS];
    logic              pend_q     [NUM_TS];
    logic              sf_sync_q;
    logic              wait_q;
    logic [DATA_W-1:0] rdata_q;
    sig_sample_t       pcm_q;
    sig_sample_t       pin_q;

    logic [IDX_W-1:0]  idx;
    logic              req;
    logic              wr_ack;
    logic [7:0]        rd_mux;

    logic [TS_W-1:0]   rts;
    logic              rx_ok;
    chan_ctrl_t        rctrl;
    logic [3:0]        cap;
    logic              do_cap;
    logic              stable;
    logic              defer;
    logic [3:0]        arr_at_rts;

    function automatic logic hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] base);
        return (a >= base) && (a < base + IDX_W'(NUM_TS));
    endfunction

    function automatic logic [TS_W-1:0] ts_of(input logic [IDX_W-1:0] a,
                                              input logic [IDX_W-1:0] base);
        logic [IDX_W-1:0] d;
        d = a - base;
        return d[TS_W-1:0];
    endfunction

    function automatic logic [3:0] extract(input ext_scheme_t e, input logic [3:0] s);
        logic [3:0] r;
        r = SIG_RESET;
        case (e)
            EXT_16:  r = s;
            EXT_4:   r = {s[SIG_A_BIT], s[SIG_B_BIT], 2'h0};
            EXT_2:   r = {s[SIG_A_BIT], 3'h0};
            default: r = SIG_RESET;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] substitute(input chan_ctrl_t c, input logic [3:0] sub,
                                              input logic [3:0] rx);
        logic [3:0] r;
        r = rx;
        if (c.sub_en) begin
            case (c.scheme)
                SUB_ONES: r = SIG_ONES;
                SUB_16:   r = sub;
                SUB_4:    r = {sub[SIG_A_BIT], sub[SIG_B_BIT], rx[1:0]};
                default:  r = {sub[SIG_A_BIT], rx[2:0]};
            endcase
        end
        return r;
    endfunction

    // bus: one wait cycle per access, answer registered
    assign idx    = address_i[ADDR_W-1:2];
    assign req    = read_i | write_i;
    assign wr_ack = write_i & ~wait_q & byteenable_i[0];

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    always_comb begin
        rd_mux = 8'h0;
        if (hit(idx, CTRL_BASE)) begin
            rd_mux[SUB_EN_BIT]               = ctrl_q[ts_of(idx, CTRL_BASE)].sub_en;
            rd_mux[DEB_EN_BIT]               = ctrl_q[ts_of(idx, CTRL_BASE)].deb_en;
            rd_mux[SCHEME_LSB+1:SCHEME_LSB]  = ctrl_q[ts_of(idx, CTRL_BASE)].scheme;
            rd_mux[EXT_LSB+1:EXT_LSB]        = ctrl_q[ts_of(idx, CTRL_BASE)].ext;
        end else if (hit(idx, SUB_BASE)) begin
            rd_mux = {4'h0, sub_q[ts_of(idx, SUB_BASE)]};
        end else if (hit(idx, ARR_BASE)) begin
            rd_mux = {4'h0, arr_q[ts_of(idx, ARR_BASE)]};
        end else if (idx == GLOBAL_IDX) begin
            rd_mux[SF_SYNC_BIT] = sf_sync_q;
        end else begin
            rd_mux = 8'h0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_q <= RDATA_RESET;
        end else if (read_i & wait_q) begin
            rdata_q <= {24'h0, rd_mux};
        end
    end

    // writes with byteenable_i[0] set land at the edge where waitrequest is low; the array has no write path
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_TS; i++) begin
                ctrl_q[i] <= CTRL_RESET;
                sub_q[i]  <= SIG_RESET;
            end
        end else if (wr_ack) begin
            if (hit(idx, CTRL_BASE)) begin
                ctrl_q[ts_of(idx, CTRL_BASE)].sub_en <= writedata_i[SUB_EN_BIT];
                ctrl_q[ts_of(idx, CTRL_BASE)].deb_en <= writedata_i[DEB_EN_BIT];
                ctrl_q[ts_of(idx, CTRL_BASE)].scheme <= sub_scheme_t'(writedata_i[SCHEME_LSB+1:SCHEME_LSB]);
                ctrl_q[ts_of(idx, CTRL_BASE)].ext    <= ext_scheme_t'(writedata_i[EXT_LSB+1:EXT_LSB]);
            end else if (hit(idx, SUB_BASE)) begin
                sub_q[ts_of(idx, SUB_BASE)] <= writedata_i[3:0];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sf_sync_q <= SYNC_RESET;
        end else if (wr_ack && idx == GLOBAL_IDX) begin
            sf_sync_q <= writedata_i[SF_SYNC_BIT];
        end
    end

    // receive side
    assign rts        = rx_sample_i.ts;
    assign rx_ok      = rx_sample_i.valid && (rts < TS_W'(NUM_TS));
    assign rctrl      = rx_ok ? ctrl_q[rts] : CTRL_RESET;
    assign arr_at_rts = rx_ok ? arr_q[rts] : SIG_RESET;
    assign cap        = extract(rctrl.ext, rx_sample_i.sig);
    assign do_cap     = rx_ok && (rctrl.ext != EXT_NONE);
    // debounce compares against the previous captured sample of the same slot
    assign stable     = ~rctrl.deb_en | (cap == prev_q[rts]);
    // boundary timing only bites with debounce on; otherwise updates are immediate
    assign defer      = rctrl.deb_en & sf_sync_q;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_TS; i++) begin
                arr_q[i] <= SIG_RESET;
            end
        end else begin
            if (superframe_end_i) begin
                for (int i = 0; i < NUM_TS; i++) begin
                    if (pend_q[i]) begin
                        arr_q[i] <= pend_val_q[i];
                    end
                end
            end
            if (do_cap && stable && !defer) begin
                arr_q[rts] <= cap;
            end
        end
    end

    // a pending value set in the boundary cycle itself waits for the next boundary
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_TS; i++) begin
                pend_q[i]     <= 1'b0;
                pend_val_q[i] <= SIG_RESET;
            end
        end else begin
            if (superframe_end_i) begin
                for (int i = 0; i < NUM_TS; i++) begin
                    pend_q[i] <= 1'b0;
                end
            end
            if (do_cap && stable && defer) begin
                pend_q[rts]     <= 1'b1;
                pend_val_q[rts] <= cap;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_TS; i++) begin
                prev_q[i] <= SIG_RESET;
            end
        end else if (do_cap) begin
            prev_q[rts] <= cap;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pcm_q <= SAMPLE_RESET;
        end else begin
            pcm_q.valid <= rx_ok;
            pcm_q.ts    <= rts;
            pcm_q.sig   <= substitute(rctrl, rx_ok ? sub_q[rts] : SIG_RESET, rx_sample_i.sig);
        end
    end

    // pin shows what the array holds, never the substitute values
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_q <= SAMPLE_RESET;
        end else begin
            pin_q.valid <= do_cap;
            pin_q.ts    <= rts;
            pin_q.sig   <= (stable && !defer) ? cap : arr_at_rts;
        end
    end

    assign readdata_o         = rdata_q;
    assign waitrequest_o      = wait_q;
    assign rx_pcm_out_o       = pcm_q;
    assign rx_signaling_pin_o = pin_q;

    a_sub_bit_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_ok && rctrl.sub_en && rctrl.scheme != SUB_ONES)
        |=> rx_pcm_out_o.sig[SIG_A_BIT] == $past(sub_q[rts][SIG_A_BIT]))
        else $error("pcm bit a not substituted");

    a_sub_bit_b: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_ok && rctrl.sub_en && (rctrl.scheme == SUB_16 || rctrl.scheme == SUB_4))
        |=> rx_pcm_out_o.sig[SIG_B_BIT] == $past(sub_q[rts][SIG_B_BIT]))
        else $error("pcm bit b not substituted");

    a_sub_bit_c: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_ok && rctrl.sub_en && rctrl.scheme != SUB_16 && rctrl.scheme != SUB_ONES)
        |=> rx_pcm_out_o.sig[SIG_C_BIT] == $past(rx_sample_i.sig[SIG_C_BIT]))
        else $error("pcm bit c wrongly substituted");

    a_sub_bit_d: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_ok && rctrl.sub_en && rctrl.scheme == SUB_16)
        |=> rx_pcm_out_o.sig[SIG_D_BIT] == $past(sub_q[rts][SIG_D_BIT]))
        else $error("pcm bit d not substituted");

    a_force_ones: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_ok && rctrl.sub_en && rctrl.scheme == SUB_ONES) |=> rx_pcm_out_o.sig == SIG_ONES)
        else $error("ones substitution missing");

    a_pass_through: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_ok && !rctrl.sub_en) |=> rx_pcm_out_o.valid && rx_pcm_out_o.sig == $past(rx_sample_i.sig))
        else $error("pcm altered without substitution");

    a_array_follows: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_ok && !rctrl.deb_en && rctrl.ext == EXT_16) |=> arr_q[$past(rts)] == $past(rx_sample_i.sig))
        else $error("array not updated at once");

    a_debounce_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        (do_cap && rctrl.deb_en && cap != prev_q[rts] && !superframe_end_i)
        |=> arr_q[$past(rts)] == $past(arr_at_rts))
        else $error("array changed on unstable signaling");

    a_extract_none: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_ok && rctrl.ext == EXT_NONE && !superframe_end_i) |=> arr_q[$past(rts)] == $past(arr_at_rts))
        else $error("array changed with extraction off");

    a_read_reserved: assert property (@(posedge clock_i) disable iff (reset_i)
        (read_i && wait_q && (hit(idx, SUB_BASE) || hit(idx, ARR_BASE))) |=> readdata_o[DATA_W-1:4] == '0)
        else $error("reserved bits read nonzero");

    a_wait_one: assert property (@(posedge clock_i) disable iff (reset_i)
        (req && wait_q) |=> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer not after one wait cycle");

    a_reset_idle: assert property (@(posedge clock_i)
        reset_i |=> readdata_o == RDATA_RESET && waitrequest_o
            && rx_pcm_out_o == SAMPLE_RESET && rx_signaling_pin_o == SAMPLE_RESET)
        else $error("outputs not idle after reset");

    a_array_no_write: assert property (@(posedge clock_i) disable iff (reset_i)
        (write_i && !wait_q && hit(idx, ARR_BASE) && !do_cap && !superframe_end_i)
        |=> arr_q[$past(ts_of(idx, ARR_BASE))] == $past(arr_q[ts_of(idx, ARR_BASE)]))
        else $error("host write reached the array");

    a_sub_write: assert property (@(posedge clock_i) disable iff (reset_i)
        (wr_ack && hit(idx, SUB_BASE))
        |=> sub_q[$past(ts_of(idx, SUB_BASE))] == $past(writedata_i[3:0]))
        else $error("substitute write missed its slot");

    a_deb_update: assert property (@(posedge clock_i) disable iff (reset_i)
        (do_cap && rctrl.deb_en && cap == prev_q[rts] && !sf_sync_q)
        |=> arr_q[$past(rts)] == $past(cap))
        else $error("stable signaling not taken into array");

    a_defer_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        (do_cap && stable && defer && !superframe_end_i)
        |=> arr_q[$past(rts)] == $past(arr_at_rts))
        else $error("array refreshed off the superframe boundary");

    a_pin_received: assert property (@(posedge clock_i) disable iff (reset_i)
        (do_cap && rctrl.sub_en && !rctrl.deb_en)
        |=> rx_signaling_pin_o.sig == $past(cap))
        else $error("signaling pin shows substitute values");

    a_refuse_slot: assert property (@(posedge clock_i) disable iff (reset_i)
        (rx_sample_i.valid && rx_sample_i.ts >= TS_W'(NUM_TS))
        |=> !rx_pcm_out_o.valid && !rx_signaling_pin_o.valid)
        else $error("sample beyond last slot produced output");
endmodule
`default_nettype wire

// ==== rx_sig_pkg.sv ====
// rx_sig_pkg: constants and types for the receive signaling substitution array.
// assumes a register index space where byte address = 4 * index.
`default_nettype none
package rx_sig_pkg;
    localparam int NUM_TS = 24;
    localparam int TS_W   = 5;
    localparam int IDX_W  = 11;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 32;

    // register indices (byte address is four times these)
    localparam logic [IDX_W-1:0] CTRL_BASE  = 11'h3a0;
    localparam logic [IDX_W-1:0] SUB_BASE   = 11'h3c0;
    localparam logic [IDX_W-1:0] ARR_BASE   = 11'h500;
    localparam logic [IDX_W-1:0] GLOBAL_IDX = 11'h107;

    // field positions
    localparam int SF_SYNC_BIT = 7;
    localparam int SUB_EN_BIT  = 6;
    localparam int DEB_EN_BIT  = 4;
    localparam int SCHEME_LSB  = 2;
    localparam int EXT_LSB     = 0;
    localparam int SIG_A_BIT   = 3;
    localparam int SIG_B_BIT   = 2;
    localparam int SIG_C_BIT   = 1;
    localparam int SIG_D_BIT   = 0;

    // reset values and the all-ones substitute value
    localparam logic [3:0]        SIG_RESET  = 4'h0;
    localparam logic              SYNC_RESET = 1'b0;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0;
    localparam logic [3:0]        SIG_ONES   = 4'hf;

    typedef enum logic [1:0] {SUB_ONES, SUB_16, SUB_4, SUB_2} sub_scheme_t;
    typedef enum logic [1:0] {EXT_NONE, EXT_16, EXT_4, EXT_2} ext_scheme_t;

    typedef struct packed {
        logic        sub_en;
        logic        deb_en;
        sub_scheme_t scheme;
        ext_scheme_t ext;
    } chan_ctrl_t;

    localparam chan_ctrl_t CTRL_RESET = '{1'b0, 1'b0, SUB_ONES, EXT_NONE};

    typedef struct packed {
        logic            valid;
        logic [TS_W-1:0] ts;
        logic [3:0]      sig;
    } sig_sample_t;

    localparam sig_sample_t SAMPLE_RESET = '{1'b0, 5'h0, 4'h0};
endpackage
`default_nettype wire

// ==== framer_model.sv ====
// framer_model: stands in for the receive framer's signaling extractor.
// assumes one bench process calls drive and boundary, never both at once.
`timescale 1ns/10ps
`default_nettype none
module framer_model (
    // clock
    input  wire logic                    clock_i,
    // toward the block
    output var rx_sig_pkg::sig_sample_t  rx_sample_o,
    output var logic                     superframe_end_o
);
    import rx_sig_pkg::*;
    logic       pv = 1'b0;
    logic [4:0] pts = 5'h0;
    logic [3:0] psig = 4'h0;
    logic [7:0] fill = 8'h0;
    initial superframe_end_o = 1'b0;
    always @(posedge clock_i) fill <= fill + 8'h1;
    // idle fields keep changing so the block cannot lean on stale values
    always_comb rx_sample_o = pv ? {1'b1, pts, psig} : {1'b0, fill[4:0], fill[7:4]};
    task automatic drive(input logic [4:0] t, input logic [3:0] s);
        @(posedge clock_i);
        pts <= t;
        psig <= s;
        pv <= 1'b1;
        @(posedge clock_i);
        pv <= 1'b0;
    endtask
    task automatic boundary();
        @(posedge clock_i);
        superframe_end_o <= 1'b1;
        @(posedge clock_i);
        superframe_end_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== rx_signaling_substitution_array_tb.sv ====
// rx_signaling_substitution_array_tb: self-checking bench for the signaling array.
// assumes one-cycle avalon answers; results are matched against queued notes.
`timescale 1ns/10ps
`default_nettype none
module rx_signaling_substitution_array_tb;
    import rx_sig_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [12:0] address = 13'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        wait_req;
    sig_sample_t sample, pcm, pin;
    logic        sf_end;
    int          bad_count = 0;
    int          tests_run = 0;
    int          seed = 71237;
    logic [31:0] qr[$];
    logic [3:0]  qp[$];
    logic [3:0]  qs[$];
    logic [3:0]  r, a, m;
    logic [3:0]  be = 4'hf;
    logic [7:0]  w;
    logic [3:0]  deb_sig[4] = '{4'h9, 4'h9, 4'h6, 4'h6};
    logic [3:0]  deb_pin[4] = '{4'h0, 4'h9, 4'h9, 4'h6};

    rx_signaling_substitution_array i_dut (.clock_i(clk), .reset_i(rst), .address_i(address),
        .read_i(read), .write_i(write), .writedata_i(wdata), .byteenable_i(be),
        .readdata_o(rdata), .waitrequest_o(wait_req), .rx_sample_i(sample),
        .superframe_end_i(sf_end), .rx_pcm_out_o(pcm), .rx_signaling_pin_o(pin));
    framer_model i_framer (.clock_i(clk), .rx_sample_o(sample), .superframe_end_o(sf_end));

    initial forever #20 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [10:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0, "bus hang");
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd(input logic [10:0] idx, input logic [31:0] exp);
        qr.push_back(exp);
        bus(1'b0, idx, 32'h0);
    endtask

    task automatic send(input logic [4:0] t, input logic [3:0] s, input logic [3:0] ep,
                        input logic pon, input logic [3:0] es);
        qp.push_back(ep);
        if (pon) qs.push_back(es);
        i_framer.drive(t, s);
    endtask

    function automatic logic [3:0] subst(input logic [1:0] s, input logic [3:0] sv, input logic [3:0] rx);
        case (s)
            2'h0: return 4'hf;
            2'h1: return sv;
            2'h2: return {sv[3:2], rx[1:0]};
            default: return {sv[3], rx[2:0]};
        endcase
    endfunction

    // the oldest note is taken whenever a result shows
    always @(posedge clk) begin
        if (wait_req === 1'b0 && read) begin
            if (qr.size() == 0) chk(32'h1, 32'h0, "extra read");
            else chk(rdata, qr.pop_front(), "read data");
        end
        if (pcm.valid === 1'b1) begin
            if (qp.size() == 0) chk(32'h1, 32'h0, "extra pcm");
            else chk({28'h0, pcm.sig}, {28'h0, qp.pop_front()}, "pcm sig");
        end
        if (pin.valid === 1'b1) begin
            if (qs.size() == 0) chk(32'h1, 32'h0, "extra pin");
            else chk({28'h0, pin.sig}, {28'h0, qs.pop_front()}, "pin sig");
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(SUB_BASE, 32'h0);
        rd(ARR_BASE + 11'd23, 32'h0);
        rd(11'h7ff, 32'h0);
        bus(1'b1, SUB_BASE, 32'hff0a);
        bus(1'b1, SUB_BASE + 11'd23, 32'hf5);
        rd(SUB_BASE, 32'h0a);
        rd(SUB_BASE + 11'd1, 32'h0);
        rd(SUB_BASE + 11'd23, 32'h05);
        bus(1'b1, ARR_BASE + 11'd5, 32'hff);
        rd(ARR_BASE + 11'd5, 32'h0);
        be <= 4'he;
        bus(1'b1, SUB_BASE + 11'd1, 32'h0f);
        be <= 4'hf;
        rd(SUB_BASE + 11'd1, 32'h0);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, CTRL_BASE + 11'd2, {24'h0, 4'h4, s[1:0], 2'h1});
            w = 8'($random(seed));
            r = 4'($random(seed));
            bus(1'b1, SUB_BASE + 11'd2, {24'h0, w});
            send(5'd2, r, subst(s[1:0], w[3:0], r), 1'b1, r);
            rd(ARR_BASE + 11'd2, {28'h0, r});
            rd(SUB_BASE + 11'd2, {28'h0, w[3:0]});
        end
        a = 4'h0;
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, CTRL_BASE + 11'd9, {30'h0, e[1:0]});
            r = 4'($random(seed));
            m = (e == 1) ? 4'hf : (e == 2) ? 4'hc : 4'h8;
            if (e != 0) a = r & m;
            send(5'd9, r, r, e != 0, a);
            rd(ARR_BASE + 11'd9, {28'h0, a});
        end
        i_framer.drive(5'd24, 4'hf);
        bus(1'b1, CTRL_BASE + 11'd7, 32'h11);
        rd(CTRL_BASE + 11'd7, 32'h11);
        for (int i = 0; i < 4; i++) send(5'd7, deb_sig[i], deb_sig[i], 1'b1, deb_pin[i]);
        rd(ARR_BASE + 11'd7, 32'h6);
        bus(1'b1, GLOBAL_IDX, 32'h80);
        rd(GLOBAL_IDX, 32'h80);
        send(5'd7, 4'h3, 4'h3, 1'b1, 4'h6);
        send(5'd7, 4'h3, 4'h3, 1'b1, 4'h6);
        rd(ARR_BASE + 11'd7, 32'h6);
        i_framer.boundary();
        rd(ARR_BASE + 11'd7, 32'h3);
        bus(1'b1, CTRL_BASE + 11'd7, 32'h01);
        send(5'd7, 4'h5, 4'h5, 1'b1, 4'h5);
        rd(ARR_BASE + 11'd7, 32'h5);
        repeat (5) @(posedge clk);
        chk(32'(qr.size() + qp.size() + qs.size()), 32'h0, "missing results");
        summarize();
    end
endmodule
`default_nettype wire
